// File: hw/crs_pkg.sv
// package: constants for the configuration reset sequencer
`default_nettype none
package crs_pkg;
  // reset delay figures, in microseconds, and the clock, in MHz
  localparam int unsigned FAST_POR_US       = 4000;
  localparam int unsigned STD_POR_US        = 100000;
  localparam int unsigned CLK_MHZ           = 40;
  // least times round up; product stays well below 2**31
  localparam int unsigned FAST_POR_CYCLES   = FAST_POR_US * CLK_MHZ;
  localparam int unsigned STD_POR_CYCLES    = STD_POR_US * CLK_MHZ;
  localparam int unsigned POR_CNT_W         = 23;
  localparam int unsigned SCHEME_W          = 4;
  // straps read once both synchroniser stages hold the pin level
  localparam int unsigned STRAP_CYCLE       = 2;
  // scheme codes that select the standard delay
  localparam logic [3:0]  SCHEME_STD_A      = 4'ha;
  localparam logic [3:0]  SCHEME_STD_B      = 4'hb;
  // axi responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  // register byte offsets
  localparam logic [3:0]  CTRL_OFS          = 4'h0;
  localparam logic [3:0]  STATUS_OFS        = 4'h4;
  // control bits
  localparam int unsigned CTRL_SOFT_REQ_BIT = 0;
  localparam int unsigned CTRL_LOADED_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET        = 2'h0;
  typedef enum logic [1:0] {
    CRS_POR   = 2'b00,
    CRS_HOLD  = 2'b01,
    CRS_READY = 2'b11
  } crs_state_e;
endpackage
`default_nettype wire

// File: hw/crs_sequencer.sv
// module: power-on and pre-configuration reset sequencer with axi4-lite status
// Summary of operation
// - during power-on reset hold status low, clear config memory, tri-state user io
// - after power-on reset keep user io tri-stated through pre-configuration and configuration
// - while the request input is low, stay in reset, accept no configuration
// - release status on leaving reset only when request is high
// - once status released, device is ready to accept configuration data; here cfg_ready stays low while the ctrl soft request bit is set
// - pull select low: weak pull-ups on after power-on reset, before and during load
// - pull select high: weak pull-ups stay disabled
// - power-on delay length chosen from the sampled scheme select pins
// - delay select high gives fast delay unless scheme code is 0xa or 0xb; low gives standard delay
// - request low pulse pulls status and load-complete low, tri-states io; restart after
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`default_nettype none
module crs_sequencer
  import crs_pkg::*;
#(
  parameter int unsigned FAST_CYCLES = crs_pkg::FAST_POR_CYCLES,
  parameter int unsigned STD_CYCLES  = crs_pkg::STD_POR_CYCLES
)(
  input  wire logic                          aclk,                // 40 MHz clock
  input  wire logic                          aresetn,             // sync reset, power-on
  input  wire logic                          reconfig_request_n,  // pin, request low = reset
  input  wire logic                          io_weak_pull_sel_n,  // pin, low enables pull-ups
  input  wire logic                          reset_delay_select,  // pin, high = fast delay unless scheme 0xa/0xb
  input  wire logic [crs_pkg::SCHEME_W-1:0]  scheme_select_pins,  // pin, scheme straps
  input  wire logic                          cfg_state_flag_n_in, // status wire level
  output logic                               cfg_state_flag_n_out,// status drive value (0)
  output logic                               cfg_state_flag_n_oe, // high while pulling low
  output logic                               load_complete_flag,  // load-complete, low in reset
  output logic                               cfg_mem_clear,       // clear config memory
  output logic                               user_io_hiz,         // tri-state user io
  output logic                               io_weak_pull_en,     // weak pull-ups on
  output logic                               cfg_ready,           // accept config data
  input  wire logic [3:0]                    s_axi_awaddr,        // write address
  input  wire logic                          s_axi_awvalid,       // write address valid
  output logic                               s_axi_awready,       // write address ready
  input  wire logic [31:0]                   s_axi_wdata,         // write data
  input  wire logic [3:0]                    s_axi_wstrb,         // write strobes
  input  wire logic                          s_axi_wvalid,        // write data valid
  output logic                               s_axi_wready,        // write data ready
  output logic [1:0]                         s_axi_bresp,         // write response
  output logic                               s_axi_bvalid,        // write response valid
  input  wire logic                          s_axi_bready,        // write response ready
  input  wire logic [3:0]                    s_axi_araddr,        // read address
  input  wire logic                          s_axi_arvalid,       // read address valid
  output logic                               s_axi_arready,       // read address ready
  output logic [31:0]                        s_axi_rdata,         // read data
  output logic [1:0]                         s_axi_rresp,         // read response
  output logic                               s_axi_rvalid,        // read data valid
  input  wire logic                          s_axi_rready         // read data ready
);
  import crs_pkg::*;

  logic [1:0]           req_sync;
  logic [1:0]           pull_sync;
  logic [1:0]           dsel_sync;
  logic [1:0]           flag_sync;
  logic [7:0]           scheme_sync0;
  logic [3:0]           scheme_sync1;
  logic                 use_fast;
  logic                 next_use_fast;
  logic                 strap_taken;
  logic                 next_strap_taken;
  logic [POR_CNT_W-1:0] por_cnt;
  logic [POR_CNT_W-1:0] next_por_cnt;
  crs_state_e           state;
  crs_state_e           next_state;
  logic [1:0]           ctrl;
  logic [1:0]           next_ctrl;
  logic                 req_ok;
  logic                 aw_held;
  logic                 w_held;
  logic [3:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 next_aw_held;
  logic                 next_w_held;
  logic [3:0]           next_aw_addr;
  logic [31:0]          next_w_data;
  logic [3:0]           next_w_strb;
  logic                 next_bvalid;
  logic [1:0]           next_bresp;
  logic                 next_rvalid;
  logic [1:0]           next_rresp;
  logic [31:0]          next_rdata;
  logic [POR_CNT_W-1:0] delay_target;

  // first stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_sync     <= 2'h0;
      pull_sync    <= 2'h3;
      dsel_sync    <= 2'h0;
      flag_sync    <= 2'h0;
      scheme_sync0 <= 8'h00;
    end
    else
    begin
      req_sync     <= {req_sync[0], reconfig_request_n};
      pull_sync    <= {pull_sync[0], io_weak_pull_sel_n};
      dsel_sync    <= {dsel_sync[0], reset_delay_select};
      flag_sync    <= {flag_sync[0], cfg_state_flag_n_in};
      scheme_sync0 <= {scheme_sync0[3:0], scheme_select_pins};
    end
  end
  assign scheme_sync1 = scheme_sync0[7:4];

  // straps caught once, two cycles after reset release
  always_comb
  begin
    next_use_fast    = use_fast;
    next_strap_taken = strap_taken;
    if (!strap_taken && state == CRS_POR && por_cnt == POR_CNT_W'(STRAP_CYCLE))
    begin
      next_strap_taken = 1'b1;
      // standard scheme codes or delay select low give the long delay
      next_use_fast    = dsel_sync[1] && scheme_sync1 != SCHEME_STD_A && scheme_sync1 != SCHEME_STD_B;
    end
  end
  assign delay_target = use_fast ? POR_CNT_W'(FAST_CYCLES) : POR_CNT_W'(STD_CYCLES);
  assign req_ok       = req_sync[1];

  always_comb
  begin
    next_state   = state;
    next_por_cnt = por_cnt;
    unique case (state)
      CRS_POR:
      begin
        // count from reset; compare only once the straps are in
        next_por_cnt = por_cnt + POR_CNT_W'(1);
        if (strap_taken && por_cnt >= delay_target)
        begin
          next_state = CRS_HOLD;
        end
      end
      CRS_HOLD:
      begin
        if (req_ok)
        begin
          next_state = CRS_READY;
        end
      end
      CRS_READY:
      begin
        if (!req_ok)
        begin
          next_state = CRS_HOLD;
        end
      end
      default:
      begin
        next_state = CRS_POR;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state       <= CRS_POR;
      por_cnt     <= '0;
      use_fast    <= 1'b0;
      strap_taken <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      por_cnt     <= next_por_cnt;
      use_fast    <= next_use_fast;
      strap_taken <= next_strap_taken;
    end
  end

  // status is open drain: we only ever pull low
  assign cfg_state_flag_n_out = 1'b0;
  assign cfg_state_flag_n_oe  = (state != CRS_READY);
  assign cfg_mem_clear        = (state == CRS_POR);
  assign user_io_hiz          = !ctrl[CTRL_LOADED_BIT] || state != CRS_READY;
  // readiness waits, two flops late, for the pulled-up status wire
  assign cfg_ready            = (state == CRS_READY) && flag_sync[1] && !ctrl[CTRL_SOFT_REQ_BIT];
  assign load_complete_flag   = (state == CRS_READY) && ctrl[CTRL_LOADED_BIT];
  assign io_weak_pull_en      = (state != CRS_POR) && !pull_sync[1] && !load_complete_flag;

  // axi4-lite slave, one write and one read at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_ctrl    = ctrl;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_SLVERR;
      if (aw_addr[3:2] == CTRL_OFS[3:2])
      begin
        next_bresp = RESP_OKAY;
        if (w_strb[0])
        begin
          next_ctrl = w_data[1:0];
        end
      end
      else if (aw_addr[3:2] == STATUS_OFS[3:2])
      begin
        next_bresp = RESP_OKAY;
      end
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    // a fresh reset phase forgets any earlier load
    if (state != CRS_READY)
    begin
      next_ctrl[CTRL_LOADED_BIT] = 1'b0;
    end
  end

  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (s_axi_araddr[3:2] == CTRL_OFS[3:2])
      begin
        next_rdata = {30'h0, ctrl};
      end
      else if (s_axi_araddr[3:2] == STATUS_OFS[3:2])
      begin
        next_rdata = {26'h0, use_fast, io_weak_pull_en, user_io_hiz, cfg_ready, state};
      end
      else
      begin
        next_rdata = 32'h0;
        next_rresp = RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0;
      ctrl         <= CTRL_RESET;
    end
    else
    begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
      ctrl         <= next_ctrl;
    end
  end

  sequence req_low_two_s;
    !reconfig_request_n [*2];
  endsequence
  status_held_por_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == CRS_POR |-> cfg_state_flag_n_oe && cfg_mem_clear && user_io_hiz)
    else $error("status or io released during power-on reset");
  io_hiz_pre_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !load_complete_flag |-> user_io_hiz)
    else $error("user io driven before load complete");
  req_low_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    req_low_two_s |=> ##1 (cfg_state_flag_n_oe && !cfg_ready))
    else $error("not held in reset while request low");
  release_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == CRS_READY) |-> $past(req_sync[1]))
    else $error("status released with request low");
  ready_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_ready |-> !cfg_state_flag_n_oe && cfg_state_flag_n_in)
    else $error("ready while status low");
  pull_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == CRS_HOLD && !pull_sync[1]) |-> io_weak_pull_en)
    else $error("pull-ups off while selected");
  pull_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pull_sync[1] |-> !io_weak_pull_en)
    else $error("pull-ups on while disabled");
  delay_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == CRS_POR && next_state == CRS_HOLD) |-> por_cnt >= delay_target)
    else $error("power-on delay too short");
  reload_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == CRS_READY && !req_ok) |=> !load_complete_flag && cfg_state_flag_n_oe)
    else $error("request pulse did not reset outputs");
endmodule
`default_nettype wire

// File: tb/crs_host_model.sv
// host-side model: drives the request pin and resolves the pulled-up status wire
`default_nettype none
module crs_host_model (
  input  wire logic       aclk,      // system clock
  input  wire logic       host_go,   // bench command: host ready to configure
  input  wire logic [3:0] lag,       // extra cycles before the host lets go
  input  wire logic       flag_out,  // device status drive value
  input  wire logic       flag_oe,   // device pulls status low
  output logic            request_n, // request pin to the device
  output logic            flag_wire  // resolved status wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;
  initial wait_cnt = 4'h0;
  // a slow host keeps request low a few cycles after it is ready
  always @(posedge aclk)
    if (!host_go)
      wait_cnt <= 4'h0;
    else if (wait_cnt != lag)
      wait_cnt <= wait_cnt + 4'h1;
  assign request_n = host_go && (wait_cnt == lag);
  // open drain with external pull-up: a released line reads high
  assign flag_wire = flag_oe ? flag_out : 1'b1;
endmodule
`default_nettype wire

// File: tb/tb_config_por_reset_sequencer.sv
// testbench: reset sequencing, pins and register bus of the reset sequencer
`default_nettype none
module tb_config_por_reset_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import crs_pkg::*;
  localparam int FAST = 20;
  localparam int STD  = 50;
  logic aclk = 1'b0, aresetn = 1'b0, host_go = 1'b0, io_weak_pull_sel_n = 1'b0, reset_delay_select = 1'b0;
  logic [3:0] lag = 4'h0, scheme_select_pins = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic reconfig_request_n, cfg_state_flag_n_in, cfg_state_flag_n_out, cfg_state_flag_n_oe, load_complete_flag;
  logic cfg_mem_clear, user_io_hiz, io_weak_pull_en, cfg_ready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fail_count = 0;
  int tests_run = 0;
  logic [3:0] strb = 4'hf;

  always #12.5 aclk = ~aclk;

  crs_sequencer #(.FAST_CYCLES(FAST), .STD_CYCLES(STD)) uut (
    .aclk, .aresetn, .reconfig_request_n, .io_weak_pull_sel_n, .reset_delay_select, .scheme_select_pins,
    .cfg_state_flag_n_in, .cfg_state_flag_n_out, .cfg_state_flag_n_oe, .load_complete_flag, .cfg_mem_clear,
    .user_io_hiz, .io_weak_pull_en, .cfg_ready, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  crs_host_model host (.aclk, .host_go, .lag, .flag_out(cfg_state_flag_n_out), .flag_oe(cfg_state_flag_n_oe),
    .request_n(reconfig_request_n), .flag_wire(cfg_state_flag_n_in));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s response %h expected %h", $time, what, got, exp);
    end
  endtask

  // scheme straps 0xa/0xb force the long delay whatever the select pin says
  function automatic int exp_len(input logic sel, input logic [3:0] sch);
    return (sel && sch != SCHEME_STD_A && sch != SCHEME_STD_B) ? FAST : STD;
  endfunction

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_release;
    int n;
    n = 0;
    while (cfg_state_flag_n_oe !== 1'b0 && n < 24)
    begin
      @(negedge aclk);
      n++;
    end
    // ready trails the two-flop status synchroniser
    repeat (2) @(negedge aclk);
  endtask

  task automatic run_por(input logic sel, input logic [3:0] sch, input logic pn);
    int n;
    @(posedge aclk);
    aresetn <= 1'b0;
    host_go <= 1'b0;
    reset_delay_select <= sel;
    scheme_select_pins <= sch;
    io_weak_pull_sel_n <= pn;
    lag <= 4'($urandom_range(6, 0));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_val(cfg_mem_clear, 1, "memory clear");
    chk_val(cfg_state_flag_n_in, 0, "status in por");
    chk_val(user_io_hiz, 1, "io in por");
    n = 0;
    while (cfg_mem_clear === 1'b1 && n < 200)
    begin
      if (n == 2)
        chk_val(io_weak_pull_en, 0, "pull in por");
      @(negedge aclk);
      n++;
    end
    chk_val(n >= exp_len(sel, sch) - 1 && n <= exp_len(sel, sch) + 4, 1, "por length");
    repeat (10) @(negedge aclk);
    chk_val(cfg_state_flag_n_oe, 1, "status held");
    chk_val(cfg_ready, 0, "held not ready");
    chk_val(user_io_hiz, 1, "io after por");
    chk_val(io_weak_pull_en, !pn, "pull enable");
    @(posedge aclk);
    host_go <= 1'b1;
    wait_release();
    chk_val(cfg_state_flag_n_in, 1, "status released");
    chk_val(cfg_ready, 1, "ready for data");
    chk_val(user_io_hiz, 1, "io in config");
  endtask

  initial
  begin
    repeat (6000) @(posedge aclk);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h757d));
    run_por(1'b0, 4'($urandom), 1'b1);
    run_por(1'b1, SCHEME_STD_A, 1'b0);
    run_por(1'b1, SCHEME_STD_B, 1'b1);
    run_por(1'b1, 4'($urandom_range(9, 0)), 1'b0);
    axi_rd(STATUS_OFS, d, r);
    chk_resp(r, RESP_OKAY, "status read");
    chk_val(d, 32'h3f, "status word");
    axi_wr(CTRL_OFS, 32'h1, r);
    @(negedge aclk);
    chk_val(cfg_ready, 0, "soft hold");
    d = $urandom;
    d[7:0] = 8'h02;
    axi_wr(CTRL_OFS, d, r);
    chk_resp(r, RESP_OKAY, "ctrl write");
    @(negedge aclk);
    chk_val(load_complete_flag, 1, "load flag");
    chk_val(user_io_hiz, 0, "io driven");
    chk_val(io_weak_pull_en, 0, "pull after load");
    axi_rd(CTRL_OFS, d, r);
    chk_val(d, 32'h2, "ctrl readback");
    // request pulse while loaded: everything must fall back
    @(posedge aclk);
    host_go <= 1'b0;
    repeat (4) @(negedge aclk);
    chk_val(cfg_state_flag_n_oe, 1, "status pulled");
    chk_val(load_complete_flag, 0, "load flag cleared");
    chk_val(user_io_hiz, 1, "io tristated");
    chk_val(cfg_ready, 0, "no data in reset");
    repeat ($urandom_range(5, 1)) @(posedge aclk);
    host_go <= 1'b1;
    wait_release();
    chk_val(cfg_ready, 1, "restart");
    axi_rd(CTRL_OFS, d, r);
    chk_val(d, 32'h0, "loaded bit cleared");
    // low byte strobe off: control must not change
    strb = 4'he;
    axi_wr(CTRL_OFS, 32'h3, r);
    strb = 4'hf;
    axi_rd(CTRL_OFS, d, r);
    chk_val(d, 32'h0, "masked write");
    axi_rd(4'h8, d, r);
    chk_resp(r, RESP_SLVERR, "unmapped read");
    chk_val(d, 32'h0, "unmapped data");
    axi_wr(4'hc, $urandom, r);
    chk_resp(r, RESP_SLVERR, "unmapped write");
    wrap_up();
  end
endmodule
`default_nettype wire
